// file: rtl/psu_pkg.sv
// Constants and carrier types for the synchronous update and override block
package psu_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_SYNC_UPDATE_PERIOD        = 8'h2c;
	localparam logic [7:0] OFF_SYNC_UPDATE_PERIOD_SHADOW = 8'h30;
	localparam logic [7:0] OFF_IRQ_ENABLE_TWO            = 8'h34;
	localparam logic [7:0] OFF_IRQ_DISABLE_TWO           = 8'h38;
	localparam logic [7:0] OFF_IRQ_MASK_TWO              = 8'h3c;
	localparam logic [7:0] OFF_IRQ_STATUS_TWO            = 8'h40;
	localparam logic [7:0] OFF_OVERRIDE_LEVELS           = 8'h44;
	localparam logic [7:0] OFF_OUTPUT_SOURCE_SELECT      = 8'h48;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int          PERIOD_W        = 4;
	localparam int          INTERVAL_LSB    = 0;
	localparam int          TICK_COUNT_LSB  = 4;
	localparam int          WRITE_OPEN_BIT  = 0;
	localparam int          UNDERRUN_BIT    = 3;
	localparam int          HIT_LSB         = 8;
	localparam int          REFRESHED_LSB   = 16;
	localparam int          HIGH_LSB        = 0;
	localparam int          LOW_LSB         = 16;
	localparam logic [31:0] IRQ_TWO_VALID   = 32'h00ffff09;
	localparam logic [31:0] RESET_WORD      = 32'h00000000;
	localparam logic [3:0]  RESET_NIBBLE    = 4'h0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PSU_MODE_MANUAL   = 2'b00,
		PSU_MODE_AUTO_CPU = 2'b01,
		PSU_MODE_AUTO_DMA = 2'b10,
		PSU_MODE_RESERVED = 2'b11
	} psu_mode_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} psu_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} psu_apb_rsp_t;

	typedef struct packed {
		logic [7:0] comparison_refreshed;
		logic [7:0] comparison_hit;
		logic       refresh_underrun;
	} psu_events_t;

	typedef struct packed {
		logic [3:0] high;
		logic [3:0] low;
	} psu_pair_t;

endpackage

// file: rtl/psu_sync_update.sv
// Update-period timer, second interrupt set and channel output override
`timescale 1ns/10ps

module psu_sync_update (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 pclk_en,
	input  wire psu_pkg::psu_apb_req_t apb_req,
	output      psu_pkg::psu_apb_rsp_t apb_rsp,
	input  wire psu_pkg::psu_mode_t   sync_refresh_mode,
	input  wire logic                 sync_period_end,
	input  wire psu_pkg::psu_events_t events,
	input  wire psu_pkg::psu_pair_t   deadband_out,
	output      psu_pkg::psu_pair_t   channel_pin,
	output      logic                 sync_update_apply,
	output      logic                 irq
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0]         update_interval;
		logic [3:0]         update_interval_shadow;
		logic [3:0]         period_tick_count;
		logic [31:0]        mask;
		logic [31:0]        status;
		logic [3:0]         high_forced_level;
		logic [3:0]         low_forced_level;
		logic [3:0]         high_source_select;
		logic [3:0]         low_source_select;
		psu_pkg::psu_pair_t pins;
		logic [31:0]        rdata;
		logic               ready;
		logic               err;
		logic               apply;
		logic               irq;
	} psu_state_t;

	psu_state_t st_reg;
	psu_state_t st_next;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, psu_pkg::OFF_SYNC_UPDATE_PERIOD) ||
			hit(a, psu_pkg::OFF_SYNC_UPDATE_PERIOD_SHADOW) ||
			hit(a, psu_pkg::OFF_IRQ_ENABLE_TWO) ||
			hit(a, psu_pkg::OFF_IRQ_DISABLE_TWO) ||
			hit(a, psu_pkg::OFF_IRQ_MASK_TWO) ||
			hit(a, psu_pkg::OFF_IRQ_STATUS_TWO) ||
			hit(a, psu_pkg::OFF_OVERRIDE_LEVELS) ||
			hit(a, psu_pkg::OFF_OUTPUT_SOURCE_SELECT);
	endfunction

	// ------------------------------------------------------------
	// Decoded strobes
	// ------------------------------------------------------------
	logic        setup;
	logic        done;
	logic        wr;
	logic        rd;
	logic        auto_mode;
	logic        tick;
	logic        elapse;
	logic [31:0] ev_word;
	logic [31:0] wdat;

	assign setup     = apb_req.psel && !apb_req.penable;
	assign done      = apb_req.psel && apb_req.penable && st_reg.ready;
	assign wr        = done && apb_req.pwrite;
	assign rd        = done && !apb_req.pwrite;
	assign wdat      = apb_req.pwdata;
	assign auto_mode = (sync_refresh_mode == psu_pkg::PSU_MODE_AUTO_CPU) ||
		(sync_refresh_mode == psu_pkg::PSU_MODE_AUTO_DMA);
	assign tick      = sync_period_end && auto_mode;
	// Compare with >= so a period shortened below the count still wraps
	assign elapse    = tick &&
		(st_reg.period_tick_count >= st_reg.update_interval);

	always_comb begin
		ev_word = psu_pkg::RESET_WORD;
		ev_word[psu_pkg::REFRESHED_LSB +: 8] =
			events.comparison_refreshed;
		ev_word[psu_pkg::HIT_LSB +: 8] = events.comparison_hit;
		ev_word[psu_pkg::UNDERRUN_BIT] = events.refresh_underrun;
		// DMA-paced mode shares the elapse trigger; mode 0 never opens it
		ev_word[psu_pkg::WRITE_OPEN_BIT] = elapse;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.apply = 1'b0;

		// Update-period timer
		if (!auto_mode) begin
			st_next.period_tick_count = psu_pkg::RESET_NIBBLE;
		end else if (tick) begin
			if (elapse) begin
				st_next.period_tick_count = psu_pkg::RESET_NIBBLE;
				st_next.apply = 1'b1;
				// Reload only at the wrap so no stray trigger is made
				st_next.update_interval =
					st_reg.update_interval_shadow;
			end else begin
				st_next.period_tick_count =
					st_reg.period_tick_count + 4'h1;
			end
		end

		// APB slave: no wait state, read data latched at setup
		if (setup) begin
			st_next.ready = 1'b1;
			st_next.err   = !mapped(apb_req.paddr);
			st_next.rdata = psu_pkg::RESET_WORD;
			unique case (apb_req.paddr)
				psu_pkg::OFF_SYNC_UPDATE_PERIOD: begin
					st_next.rdata[psu_pkg::TICK_COUNT_LSB +: 4] =
						st_reg.period_tick_count;
					st_next.rdata[psu_pkg::INTERVAL_LSB +: 4] =
						st_reg.update_interval;
				end
				psu_pkg::OFF_IRQ_MASK_TWO: begin
					st_next.rdata = st_reg.mask;
				end
				psu_pkg::OFF_IRQ_STATUS_TWO: begin
					st_next.rdata = st_reg.status;
				end
				psu_pkg::OFF_OVERRIDE_LEVELS: begin
					st_next.rdata[psu_pkg::HIGH_LSB +: 4] =
						st_reg.high_forced_level;
					st_next.rdata[psu_pkg::LOW_LSB +: 4] =
						st_reg.low_forced_level;
				end
				psu_pkg::OFF_OUTPUT_SOURCE_SELECT: begin
					st_next.rdata[psu_pkg::HIGH_LSB +: 4] =
						st_reg.high_source_select;
					st_next.rdata[psu_pkg::LOW_LSB +: 4] =
						st_reg.low_source_select;
				end
				default: begin
					st_next.rdata = psu_pkg::RESET_WORD;
				end
			endcase
		end else if (done) begin
			st_next.ready = 1'b0;
			st_next.err   = 1'b0;
		end

		// Register writes take effect at the completing edge
		if (wr) begin
			unique case (apb_req.paddr)
				psu_pkg::OFF_SYNC_UPDATE_PERIOD: begin
					// Keep the shadow in step so a later wrap reloads it
					st_next.update_interval =
						wdat[psu_pkg::INTERVAL_LSB +: 4];
					st_next.update_interval_shadow =
						wdat[psu_pkg::INTERVAL_LSB +: 4];
				end
				psu_pkg::OFF_SYNC_UPDATE_PERIOD_SHADOW: begin
					st_next.update_interval_shadow =
						wdat[psu_pkg::INTERVAL_LSB +: 4];
				end
				psu_pkg::OFF_IRQ_ENABLE_TWO: begin
					st_next.mask = st_reg.mask |
						(wdat & psu_pkg::IRQ_TWO_VALID);
				end
				psu_pkg::OFF_IRQ_DISABLE_TWO: begin
					st_next.mask = st_reg.mask &
						~(wdat & psu_pkg::IRQ_TWO_VALID);
				end
				psu_pkg::OFF_OVERRIDE_LEVELS: begin
					st_next.high_forced_level =
						wdat[psu_pkg::HIGH_LSB +: 4];
					st_next.low_forced_level =
						wdat[psu_pkg::LOW_LSB +: 4];
				end
				psu_pkg::OFF_OUTPUT_SOURCE_SELECT: begin
					st_next.high_source_select =
						wdat[psu_pkg::HIGH_LSB +: 4];
					st_next.low_source_select =
						wdat[psu_pkg::LOW_LSB +: 4];
				end
				default: begin
					st_next.mask = st_reg.mask;
				end
			endcase
		end

		// Sticky flags; an event in the clearing cycle survives
		if (rd && hit(apb_req.paddr, psu_pkg::OFF_IRQ_STATUS_TWO)) begin
			// Clear only what the read returned: a flag raised at the
			// setup edge was not reported yet and must stay set
			st_next.status = (st_reg.status & ~st_reg.rdata) |
				ev_word;
		end else begin
			st_next.status = st_reg.status | ev_word;
		end

		st_next.irq = |(st_next.status & st_next.mask);

		st_next.pins.high =
			(st_reg.high_source_select & st_reg.high_forced_level) |
			(~st_reg.high_source_select & deadband_out.high);
		st_next.pins.low =
			(st_reg.low_source_select & st_reg.low_forced_level) |
			(~st_reg.low_source_select & deadband_out.low);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else if (pclk_en) begin
			st_reg <= st_next;
		end
	end

	assign apb_rsp.prdata     = st_reg.rdata;
	assign apb_rsp.pready     = st_reg.ready;
	assign apb_rsp.pslverr    = st_reg.err;
	assign channel_pin        = st_reg.pins;
	assign sync_update_apply  = st_reg.apply;
	assign irq                = st_reg.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic wr_en_go;
	logic wr_dis_go;
	logic rd_st_go;
	assign wr_en_go  = pclk_en && wr &&
		hit(apb_req.paddr, psu_pkg::OFF_IRQ_ENABLE_TWO);
	assign wr_dis_go = pclk_en && wr &&
		hit(apb_req.paddr, psu_pkg::OFF_IRQ_DISABLE_TWO);
	assign rd_st_go  = pclk_en && rd &&
		hit(apb_req.paddr, psu_pkg::OFF_IRQ_STATUS_TWO);

	chk_mask_set_ones: assert property (
		wr_en_go |=> ((st_reg.mask & $past(wdat & psu_pkg::IRQ_TWO_VALID))
			== $past(wdat & psu_pkg::IRQ_TWO_VALID)))
		else $error("enable write did not set mask bits");

	chk_mask_clear_ones: assert property (
		wr_dis_go |=> ((st_reg.mask & $past(wdat)) == 32'h00000000))
		else $error("disable write did not clear mask bits");

	chk_mask_only_writes: assert property (
		!wr_en_go && !wr_dis_go |=> $stable(st_reg.mask))
		else $error("mask changed without a write");

	chk_status_read_clear: assert property (
		rd_st_go && (ev_word == 32'h00000000)
		|=> ((st_reg.status & $past(apb_rsp.prdata)) == 32'h00000000))
		else $error("status read did not clear flags");

	chk_hit_flag_sticky: assert property (
		pclk_en && (events.comparison_hit != 8'h00)
		|=> ((st_reg.status[15:8] & $past(events.comparison_hit))
			== $past(events.comparison_hit)))
		else $error("hit flag not set");

	chk_refresh_sticky: assert property (
		pclk_en && !rd_st_go |=>
		((st_reg.status[23:16] & $past(st_reg.status[23:16]))
			== $past(st_reg.status[23:16])))
		else $error("refreshed flag lost without a read");

	chk_underrun_flag: assert property (
		pclk_en && events.refresh_underrun |=> st_reg.status[3])
		else $error("underrun flag not set");

	chk_window_mode0: assert property (
		pclk_en && (sync_refresh_mode == psu_pkg::PSU_MODE_MANUAL) &&
		!st_reg.status[0] |=> !st_reg.status[0])
		else $error("write window opened in manual mode");

	chk_apply_cause: assert property (
		sync_update_apply && $past(pclk_en) |->
		$past(sync_period_end && auto_mode &&
			(st_reg.period_tick_count >= st_reg.update_interval)))
		else $error("update applied without an elapsed period");

	chk_shadow_hold: assert property (
		pclk_en && wr && !elapse &&
		hit(apb_req.paddr, psu_pkg::OFF_SYNC_UPDATE_PERIOD_SHADOW)
		|=> $stable(st_reg.update_interval))
		else $error("shadow write changed active period early");

	chk_irq_level: assert property (
		irq == |(st_reg.status & st_reg.mask))
		else $error("interrupt level disagrees with flags");

	chk_high_override: assert property (
		pclk_en |=> channel_pin.high ==
		$past((st_reg.high_source_select & st_reg.high_forced_level) |
			(~st_reg.high_source_select & deadband_out.high)))
		else $error("high pin source wrong");

	chk_low_override: assert property (
		pclk_en |=> channel_pin.low ==
		$past((st_reg.low_source_select & st_reg.low_forced_level) |
			(~st_reg.low_source_select & deadband_out.low)))
		else $error("low pin source wrong");

	// ------------------------------------------------------------
	// Timer, register and interrupt checks
	// ------------------------------------------------------------
	chk_tick_advance: assert property (
		pclk_en && tick && !elapse |=> (st_reg.period_tick_count ==
			$past(st_reg.period_tick_count) + 4'h1))
		else $error("update period counter did not advance");

	chk_count_hold: assert property (
		pclk_en && !auto_mode |=> (st_reg.period_tick_count == 4'h0))
		else $error("update period counter ran in manual mode");

	chk_window_on_elapse: assert property (
		pclk_en && elapse |=> st_reg.status[0] && sync_update_apply)
		else $error("elapsed period did not open write window");

	chk_reload_at_wrap: assert property (
		pclk_en && elapse && !wr |=> (st_reg.update_interval ==
			$past(st_reg.update_interval_shadow)))
		else $error("shadow period not loaded at wrap");

	chk_forced_written: assert property (
		pclk_en && wr &&
		hit(apb_req.paddr, psu_pkg::OFF_OVERRIDE_LEVELS)
		|=> (st_reg.high_forced_level == $past(wdat[3:0])) &&
			(st_reg.low_forced_level == $past(wdat[19:16])))
		else $error("forced levels not written");

	chk_select_written: assert property (
		pclk_en && wr &&
		hit(apb_req.paddr, psu_pkg::OFF_OUTPUT_SOURCE_SELECT)
		|=> (st_reg.high_source_select == $past(wdat[3:0])) &&
			(st_reg.low_source_select == $past(wdat[19:16])))
		else $error("source selects not written");

	chk_mask_valid_bits: assert property (
		(st_reg.mask & ~psu_pkg::IRQ_TWO_VALID) == 32'h00000000)
		else $error("mask holds an unused bit");

	chk_irq_on_event: assert property (
		pclk_en && !wr_dis_go && ((ev_word & st_reg.mask) != 32'h0)
		|=> irq)
		else $error("unmasked event did not raise interrupt");

	cov_auto_apply: cover property (sync_update_apply);
	cov_irq_rise: cover property ($rose(irq));
	cov_read_with_event: cover property (rd_st_go && ev_word != 32'h0);
	cov_bad_address: cover property (apb_rsp.pslverr && done);
	cov_frozen_tick: cover property (!pclk_en && sync_period_end);

endmodule

// file: tb/psu_gate_model.sv
// Gate driver model watching the channel pins of all four channels
`timescale 1ns/10ps

module psu_gate_model (
	input  wire psu_pkg::psu_pair_t pins,
	input  wire logic               pclk,
	output      int                 overlap_cnt
);
	// ------------------------------------------------------------
	// Shoot-through watch
	// ------------------------------------------------------------
	// Both legs on would short a real bridge; the bench only reports it,
	// since forced levels may legally request it
	initial overlap_cnt = 0;
	always @(posedge pclk) begin
		if ((pins.high & pins.low) !== 4'h0)
			overlap_cnt <= overlap_cnt + 1;
	end
endmodule

// file: tb/tb_psu_sync_update.sv
// Self-checking testbench for the update timer and output override block
`timescale 1ns/10ps

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module tb_psu_sync_update;
	logic                  pclk = 1'b0;
	logic                  presetn = 1'b0;
	logic                  pclk_en = 1'b1;
	psu_pkg::psu_apb_req_t apb_req = '0;
	psu_pkg::psu_apb_rsp_t apb_rsp;
	psu_pkg::psu_mode_t    mode = psu_pkg::PSU_MODE_MANUAL;
	logic                  period_end = 1'b0;
	psu_pkg::psu_events_t  events = '0;
	psu_pkg::psu_pair_t    deadband = '0;
	psu_pkg::psu_pair_t    pins;
	logic                  apply;
	logic                  irq;
	int                    overlap_cnt;
	int                    err_total = 0;
	int                    tests_run = 0;
	int                    apply_cnt = 0;
	logic [31:0]           seed = 32'hb59f5280;
	logic [31:0]           q, r, m, lv, sl, ex;
	logic                  e;
	logic [3:0]            n, s;

	always #20 pclk = ~pclk;

	psu_sync_update i_dut (
		.pclk              (pclk),
		.presetn           (presetn),
		.pclk_en           (pclk_en),
		.apb_req           (apb_req),
		.apb_rsp           (apb_rsp),
		.sync_refresh_mode (mode),
		.sync_period_end   (period_end),
		.events            (events),
		.deadband_out      (deadband),
		.channel_pin       (pins),
		.sync_update_apply (apply),
		.irq               (irq)
	);

	psu_gate_model i_gate (
		.pins        (pins),
		.pclk        (pclk),
		.overlap_cnt (overlap_cnt)
	);

	always @(posedge pclk) begin
		if (apply === 1'b1)
			apply_cnt++;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] stat_exp(input logic [16:0] ev);
		return {8'h00, ev[16:9], ev[8:1], 4'h0, ev[0], 3'b000};
	endfunction

	function automatic logic [7:0] pin_exp(input logic [31:0] l,
		input logic [31:0] c, input logic [7:0] d);
		return {(c[3:0] & l[3:0]) | (~c[3:0] & d[7:4]),
			(c[19:16] & l[19:16]) | (~c[19:16] & d[3:0])};
	endfunction

	// Holds the request until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do
			@(posedge pclk);
		while (apb_rsp.pready !== 1'b1);
		q = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	task automatic pend();
		@(posedge pclk);
		period_end <= 1'b1;
		@(posedge pclk);
		period_end <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d overlaps %0d", tests_run,
			err_total, overlap_cnt);
		if (err_total == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		summarize();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'h2c + 8'(i) * 8'h4 + (i > 0 ? 8'h0c : 8'h0), 0);
			`CHK(q, psu_pkg::RESET_WORD)
		end
		apb(1'b0, 8'h00, 0);
		`CHK(e, 1'b1)
		apb(1'b0, psu_pkg::OFF_SYNC_UPDATE_PERIOD_SHADOW, 0);
		`CHK(q, 32'h0)
		m = 0;
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			apb(1'b1, psu_pkg::OFF_IRQ_ENABLE_TWO, r);
			m |= r & psu_pkg::IRQ_TWO_VALID;
			apb(1'b0, psu_pkg::OFF_IRQ_MASK_TWO, 0);
			`CHK(q, m)
			r = rnd();
			apb(1'b1, psu_pkg::OFF_IRQ_DISABLE_TWO, r);
			m &= ~r;
			apb(1'b0, psu_pkg::OFF_IRQ_MASK_TWO, 0);
			`CHK(q, m)
		end
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			@(posedge pclk);
			events <= r[16:0];
			@(posedge pclk);
			events <= '0;
			repeat (2) @(posedge pclk);
			ex = stat_exp(r[16:0]);
			`CHK(irq, |(ex & m))
			apb(1'b0, psu_pkg::OFF_IRQ_STATUS_TWO, 0);
			`CHK(q, ex)
			apb(1'b0, psu_pkg::OFF_IRQ_STATUS_TWO, 0);
			`CHK(q, 32'h0)
		end
		// Event raised at the setup edge of a status read must survive
		r = rnd();
		fork
			apb(1'b0, psu_pkg::OFF_IRQ_STATUS_TWO, 0);
			begin
				@(posedge pclk);
				events <= r[16:0];
				@(posedge pclk);
				events <= '0;
			end
		join
		`CHK(q, 32'h0)
		apb(1'b0, psu_pkg::OFF_IRQ_STATUS_TWO, 0);
		`CHK(q, stat_exp(r[16:0]))
		for (int i = 0; i < 6; i++) begin
			lv = rnd();
			sl = rnd();
			apb(1'b1, psu_pkg::OFF_OVERRIDE_LEVELS, lv);
			apb(1'b1, psu_pkg::OFF_OUTPUT_SOURCE_SELECT, sl);
			deadband <= 8'(rnd());
			repeat (3) @(posedge pclk);
			`CHK(pins, pin_exp(lv, sl, deadband))
			apb(1'b0, psu_pkg::OFF_OVERRIDE_LEVELS, 0);
			`CHK(q, lv & 32'h000f000f)
			apb(1'b0, psu_pkg::OFF_OUTPUT_SOURCE_SELECT, 0);
			`CHK(q, sl & 32'h000f000f)
		end
		apb(1'b1, psu_pkg::OFF_IRQ_DISABLE_TWO, 32'hffffffff);
		apb(1'b1, psu_pkg::OFF_IRQ_ENABLE_TWO, 32'h1);
		// Manual and reserved modes must never count or apply
		for (int md = 0; md < 4; md += 3) begin
			mode <= psu_pkg::psu_mode_t'(md);
			apply_cnt = 0;
			repeat (3) pend();
			`CHK(apply_cnt, 0)
			apb(1'b0, psu_pkg::OFF_IRQ_STATUS_TWO, 0);
			`CHK(q, 32'h0)
		end
		for (int md = 1; md < 3; md++) begin
			mode <= psu_pkg::psu_mode_t'(md);
			n = 4'(rnd() % 4) + 4'h1;
			s = 4'h5 - n;
			apb(1'b1, psu_pkg::OFF_SYNC_UPDATE_PERIOD, {28'h0, n});
			apb(1'b1, psu_pkg::OFF_SYNC_UPDATE_PERIOD_SHADOW, {28'h0, s});
			apply_cnt = 0;
			for (int k = 1; k <= n + s + 2; k++) begin
				pend();
				`CHK(apply_cnt, int'(k > n) + int'(k > n + s + 1))
				if (k == 1) begin
					apb(1'b0, psu_pkg::OFF_SYNC_UPDATE_PERIOD, 0);
					`CHK(q, {24'h0, 4'h1, n})
				end
			end
			`CHK(irq, 1'b1)
			apb(1'b0, psu_pkg::OFF_IRQ_STATUS_TWO, 0);
			`CHK(q, 32'h1)
			repeat (2) @(posedge pclk);
			`CHK(irq, 1'b0)
		end
		// Frozen enable: period ends must neither count nor apply
		apply_cnt = 0;
		@(posedge pclk);
		pclk_en <= 1'b0;
		repeat (3) pend();
		pclk_en <= 1'b1;
		`CHK(apply_cnt, 0)
		apb(1'b0, psu_pkg::OFF_SYNC_UPDATE_PERIOD, 0);
		`CHK(q, {24'h0, 4'h0, s})
		summarize();
	end
endmodule
